// File: dv/eecl_far_model.sv
// serial eeprom and management bus partner of the loader
`timescale 1ns/1ps
module eecl_far_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ee_rd_i,
    input wire logic [7:0] ee_addr_i,
    output logic ee_ack_o,
    output logic [15:0] ee_data_o,
    input wire logic mdio_wr_i,
    input wire logic [4:0] mdio_phy_i,
    input wire logic [4:0] mdio_reg_i,
    input wire logic [15:0] mdio_data_i,
    output logic mdio_done_o,
    input wire logic [1:0] img_i, // 0 good, 1 blank, 2 bad sum, 3 normal mode
    input wire logic slow_i // stretch every fetch answer
);
    logic [15:0] word_q; // last word handed out
    logic [1:0] wait_q; // answer delay left
    logic busy_q; // fetch pending
    logic [1:0] md_q; // management write delay left
    int fetch_n; // fetches seen since reset
    logic [25:0] wlog[$]; // management writes seen
    // image content, byte sum of 07h..0Eh is 18h
    function automatic logic [15:0] img(input logic [7:0] a);
        case (a)
            8'h00: img = (img_i == 2'h1) ? 16'hFFFF : 16'h0015;
            8'h01: img = 16'h0001;
            8'h04: img = 16'h3412;
            8'h05: img = 16'h7856;
            8'h06: img = 16'hBC9A;
            8'h0F: img = (img_i == 2'h3) ? 16'h0000 : 16'hE000;
            8'h10: img = 16'h0400;
            8'h11: img = 16'h0203;
            8'h12: img = 16'h0408;
            8'h18: img = (img_i == 2'h2) ? 16'h10E6 : 16'h10E7;
            8'h2C: img = 16'h4000;
            8'h2D: img = 16'h0032;
            default: img = (a >= 8'h07 && a <= 8'h0E) ? 16'h0102 : 16'h0000;
        endcase
    endfunction : img
    // released data line shows the inverse of the last word
    assign ee_data_o = ee_ack_o ? word_q : ~word_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ee_ack_o <= 1'b0;
            busy_q <= 1'b0;
            mdio_done_o <= 1'b0;
            md_q <= 2'h0;
            fetch_n <= 0;
        end else begin
            ee_ack_o <= 1'b0;
            mdio_done_o <= 1'b0;
            if (ee_rd_i) begin
                busy_q <= 1'b1;
                wait_q <= slow_i ? 2'h3 : 2'h0;
                fetch_n <= fetch_n + 1;
            end else if (busy_q && wait_q == 2'h0) begin
                ee_ack_o <= 1'b1;
                busy_q <= 1'b0;
                word_q <= img(ee_addr_i);
            end else if (busy_q) begin
                wait_q <= wait_q - 2'h1;
            end
            if (mdio_wr_i) begin
                wlog.push_back({mdio_phy_i, mdio_reg_i, mdio_data_i});
                md_q <= 2'h2;
            end else if (md_q == 2'h1) begin
                mdio_done_o <= 1'b1;
                md_q <= 2'h0;
            end else if (md_q != 2'h0) begin
                md_q <= md_q - 2'h1;
            end
        end
    end
endmodule : eecl_far_model

// File: dv/tb_eeprom_config_loader.sv
// self-checking bench of the configuration loader
`timescale 1ns/1ps
module tb_eeprom_config_loader;
    logic clk, rst_n, ee_rd, ee_ack, md_wr, md_done, rmii, wol, fdx, rd, wr, slow;
    logic [7:0] ee_addr, raddr, attr, pwr;
    logic [15:0] ee_data, md_data, free;
    logic [4:0] md_phy, md_reg, pa, ea;
    logic [31:0] wdata, rdata, d;
    logic [1:0] img, lvl;
    logic cfg_valid, ephy_rst_n, an, s100, fd, pause, jam, sp, rwu, ad;
    logic [2:0] mode, pk, sk;
    logic [11:0] frame;
    logic [47:0] mac;
    int error_cnt = 0, check_count = 0;
    eecl_loader dut_u (.clk_i(clk), .rst_n_i(rst_n), .ee_rd_o(ee_rd), .ee_addr_o(ee_addr),
        .ee_ack_i(ee_ack), .ee_data_i(ee_data), .mdio_wr_o(md_wr), .mdio_phy_o(md_phy),
        .mdio_reg_o(md_reg), .mdio_data_o(md_data), .mdio_done_i(md_done), .rmii_mac_i(rmii),
        .wol_ready_i(wol), .full_duplex_i(fdx), .free_bytes_i(free), .reg_addr_i(raddr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .cfg_valid_o(cfg_valid), .ephy_rst_n_o(ephy_rst_n), .embedded_phy_mode_sel_o(mode),
        .ephy_autoneg_o(an), .ephy_speed100_o(s100), .ephy_full_duplex_o(fd),
        .max_frame_o(frame), .prim_phy_kind_code_o(pk), .prim_phy_mgmt_addr_o(pa),
        .sec_phy_kind_code_o(sk), .external_media_port_addr_o(ea), .pause_o(pause),
        .jam_o(jam), .mac_addr_o(mac), .cfg_attr_o(attr), .max_power_o(pwr),
        .self_powered_o(sp), .remote_wakeup_o(rwu), .cable_off_auto_disconnect_o(ad),
        .cable_off_level_o(lvl));
    eecl_far_model u_far (.clk_i(clk), .rst_n_i(rst_n), .ee_rd_i(ee_rd), .ee_addr_i(ee_addr),
        .ee_ack_o(ee_ack), .ee_data_o(ee_data), .mdio_wr_i(md_wr), .mdio_phy_i(md_phy),
        .mdio_reg_i(md_reg), .mdio_data_i(md_data), .mdio_done_o(md_done), .img_i(img),
        .slow_i(slow));
    always #5 clk = ~clk;
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        raddr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        raddr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd
    // reset with a chosen image and straps, then wait for the load
    task automatic boot(input logic [1:0] s, input logic r, input logic w, input logic l);
        int n;
        n = 0;
        img <= s;
        rmii <= r;
        wol <= w;
        slow <= l;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        u_far.wlog.delete();
        @(posedge clk);
        #1 chk(ephy_rst_n, 1'b0, "phy reset");
        while (cfg_valid !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) begin
            error_cnt++;
            summarize();
        end
        chk(u_far.fetch_n, 24, "fetches");
        repeat (30) @(posedge clk);
    endtask : boot
    task automatic t_good();
        logic [4:0] pd[3] = '{5'h00, 5'h03, 5'h02};
        chk({mode, an, s100, fd}, 6'b111000, "mode");
        chk(frame, 12'h400, "frame");
        chk({pk, pa}, 8'h03, "primary");
        chk({sk, ea}, 8'h02, "media port");
        chk(mac, 48'hBC9A78563412, "mac");
        chk({attr, pwr}, 16'hC032, "descriptor");
        chk({sp, rwu, ad, lvl}, 5'b10100, "flags");
        chk(u_far.wlog.size(), 3, "pd count");
        for (int i = 0; i < 3; i++) begin
            chk(u_far.wlog[i], {pd[i], eecl_pkg::PD_REG, eecl_pkg::PD_DATA}, "pd");
        end
    endtask : t_good
    task automatic t_host();
        u_far.wlog.delete();
        reg_wr(eecl_pkg::A_PHYSEL, 32'h00000083);
        reg_wr(eecl_pkg::A_PHYDATA, 32'h00001234);
        repeat (10) @(posedge clk);
        chk(u_far.wlog.size(), 1, "host count");
        chk(u_far.wlog[0], {5'h03, 5'h04, 16'h1234}, "host write");
        chk({ephy_rst_n, mode}, 4'hF, "no reapply");
        reg_rd(eecl_pkg::A_MACLO, d);
        chk(d, 32'h78563412, "mac lo");
        reg_rd(eecl_pkg::A_MACHI, d);
        chk(d, 32'h0000BC9A, "mac hi");
    endtask : t_host
    task automatic t_rom(input logic [3:0] st);
        reg_rd(eecl_pkg::A_STATUS, d);
        chk(d[3:0], st, "status");
        chk({mode, an, frame}, 16'h1600, "rom mode");
        chk({pk, pa, sk, ea}, 16'h10E0, "rom phys");
        chk(mac, 48'h0, "rom mac");
        chk({attr, pwr}, 16'hE002, "rom descriptor");
        chk({sp, rwu, ad, lvl}, 5'b11000, "rom flags");
        chk(u_far.wlog.size(), 0, "no pd");
        reg_rd(8'h40, d);
        chk(d, 32'h0, "unmapped");
    endtask : t_rom
    task automatic t_flow();
        logic [15:0] fv[6] = '{16'd513, 16'd512, 16'd1023, 16'd1024, 16'd600, 16'd512};
        logic [1:0] ev[6] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b00, 2'b01};
        chk({mode, an}, 4'b0001, "normal mode");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            free <= fv[i];
            fdx <= (i < 4);
            repeat (3) @(posedge clk);
            #1 chk({pause, jam}, ev[i], "flow");
        end
    endtask : t_flow
    initial begin
        {clk, rst_n, rd, wr, rmii, wol, slow} = 7'h00;
        {raddr, wdata, img} = '0;
        fdx = 1'b1;
        free = 16'hFFFF;
        boot(2'h0, 1'b1, 1'b0, 1'b0);
        t_good();
        t_host();
        boot(2'h1, 1'b1, 1'b1, 1'b0);
        t_rom(4'hB);
        boot(2'h2, 1'b0, 1'b0, 1'b0);
        t_rom(4'hD);
        boot(2'h3, 1'b0, 1'b0, 1'b1);
        t_flow();
        summarize();
    end
endmodule : tb_eeprom_config_loader

// File: logic/eecl_loader.sv
// power-on configuration loader with image fallback and phy power-down
// Summary of operation
// RL1: mode 111 gives fixed 10M half duplex
// RL2: image should hold mode 000, full autonegotiation
// RL3: mode latched once as embedded phy leaves reset
// RL4: host may still write phy registers afterwards
// RL5: frame size even, at most 2048, default 0600h
// RL6: kind 000 ethernet phy, 111 no phy
// RL7: defaults 10h and E0h, embedded phy at 10h
// RL8: secondary address serves external media port
// RL9: full duplex pause between high and low marks
// RL10: one watermark unit equals 128 bytes
// RL11: half duplex jams on same watermarks
// RL12: three power-down writes: broadcast, primary, secondary
// RL13: power-down only in rmii external phy mode
// RL14: wake-ready mode skips the power-down writes
// RL15: built-in image replaces blank or bad image
// RL16: image words are low byte then high
// RL17: built-in image loads all-zero station address
// RL18: built-in checksum FF, word 0 high 00
// RL19: built-in image is fixed read-only content
// RL20: word 2Ch high byte gives attributes, bit7 one
// RL21: word 2Dh low byte gives power in 2mA
// RL22: default self powered with remote wakeup
// RL23: default auto disconnect off, level zero
// RL24: preload 15h words after reset
// RL25: checksum equals FF minus byte sum 07h-0Eh
// RL26: selection done before descriptors are answered
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module eecl_loader (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic ee_rd_o, // word read request pulse
    output logic [7:0] ee_addr_o, // word offset
    input wire logic ee_ack_i, // word ready pulse
    input wire logic [15:0] ee_data_i, // word, low byte in [7:0]
    output logic mdio_wr_o, // management write request pulse
    output logic [4:0] mdio_phy_o,
    output logic [4:0] mdio_reg_o,
    output logic [15:0] mdio_data_o,
    input wire logic mdio_done_i, // management write finished pulse
    input wire logic rmii_mac_i, // strap pin: mac mode, external rmii phy
    input wire logic wol_ready_i, // strap pin: default wake-ready mode
    input wire logic full_duplex_i,
    input wire logic [15:0] free_bytes_i, // free receive storage in bytes
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic cfg_valid_o, // configuration selected and applied
    output logic ephy_rst_n_o, // embedded phy reset release
    output logic [2:0] embedded_phy_mode_sel_o,
    output logic ephy_autoneg_o,
    output logic ephy_speed100_o,
    output logic ephy_full_duplex_o,
    output logic [11:0] max_frame_o,
    output logic [2:0] prim_phy_kind_code_o,
    output logic [4:0] prim_phy_mgmt_addr_o,
    output logic [2:0] sec_phy_kind_code_o,
    output logic [4:0] external_media_port_addr_o,
    output logic pause_o,
    output logic jam_o,
    output logic [47:0] mac_addr_o,
    output logic [7:0] cfg_attr_o,
    output logic [7:0] max_power_o,
    output logic self_powered_o,
    output logic remote_wakeup_o,
    output logic cable_off_auto_disconnect_o,
    output logic [1:0] cable_off_level_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        S_REQ, S_WAIT, S_CHECK, S_APPLY, S_PD, S_PD_WAIT, S_RUN, S_HW_WAIT
    } eecl_state_e;
    typedef struct packed {
        eecl_state_e st; // sequencer state
        logic [7:0] addr; // word being fetched
        logic [15:0] flag, mode, frame, phy, wm, ck, attr, pwr; // stored words
        logic [15:0] mdata, hdata; // management and host write data
        logic [47:0] mac; // station address
        logic [7:0] sum; // byte sum of the checked words
        logic rd, mwr, hpend, pd_done; // requests, pending host write, done
        logic blank, bad, use_rom, valid, ephy_rst_n;
        logic autoneg, s100, fdx, fc, pause, jam; // decoded mode, flow control
        logic [11:0] max_frame;
        logic [4:0] mphy, mreg, sel_phy, sel_reg; // management and host targets
        logic [1:0] pd_idx; // power-down step
        logic [31:0] rdata;
        logic [1:0] sy1, sy2, straps; // strap synchroniser and capture
    } eecl_st_s;
    eecl_st_s q, d;
    logic [15:0] hi_b, lo_b; // watermarks in bytes
    logic [2:0] msel; // mode field of the stored word

    assign hi_b = 16'(q.wm[15:8]) << eecl_pkg::WM_SHIFT; // RL10
    assign lo_b = 16'(q.wm[7:0]) << eecl_pkg::WM_SHIFT; // RL10
    assign msel = q.mode[15:13];

    // next word to fetch after the current one
    function automatic logic [7:0] next_addr(input logic [7:0] a);
        if (a == eecl_pkg::PRELOAD_WORDS - 8'h01) begin
            next_addr = eecl_pkg::W_CKSUM;
        end else if (a == eecl_pkg::W_CKSUM) begin
            next_addr = eecl_pkg::W_ATTR;
        end else begin
            next_addr = a + 8'h01;
        end
    endfunction : next_addr

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        d = q;
        d.rd = 1'b0;
        d.mwr = 1'b0;
        d.sy1 = {rmii_mac_i, wol_ready_i};
        d.sy2 = q.sy1;
        // register writes; set of a pending host write wins
        if (reg_wr_i) begin
            if (reg_addr_i == eecl_pkg::A_PHYSEL) begin
                d.sel_phy = reg_wdata_i[4:0];
                d.sel_reg = reg_wdata_i[9:5];
            end else if (reg_addr_i == eecl_pkg::A_PHYDATA) begin
                d.hdata = reg_wdata_i[15:0];
            end
        end
        // register reads, data one cycle later
        d.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                eecl_pkg::A_STATUS: d.rdata = {26'h0, q.hpend, q.pd_done,
                    q.use_rom, q.bad, q.blank, q.valid};
                eecl_pkg::A_PHYSEL: d.rdata = {22'h0, q.sel_reg, q.sel_phy};
                eecl_pkg::A_PHYDATA: d.rdata = {16'h0, q.hdata};
                eecl_pkg::A_MACLO: d.rdata = q.mac[31:0];
                eecl_pkg::A_MACHI: d.rdata = {16'h0, q.mac[47:32]};
                default: d.rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
        // flow control hysteresis once configured
        if (q.valid) begin
            if (!q.fc && free_bytes_i <= hi_b) begin
                d.fc = 1'b1; // RL9
            end else if (q.fc && free_bytes_i >= lo_b) begin
                d.fc = 1'b0; // RL9
            end
        end
        d.pause = d.fc && full_duplex_i; // RL9
        d.jam = d.fc && !full_duplex_i; // RL11
        case (q.st)
            // fetch one word
            S_REQ: begin
                d.rd = 1'b1; // RL24
                d.st = S_WAIT;
            end
            // store the word that arrives
            S_WAIT: begin
                if (ee_ack_i) begin
                    case (q.addr) // RL16
                        eecl_pkg::W_BLANK: d.blank = ee_data_i == eecl_pkg::BLANK_WORD;
                        eecl_pkg::W_FLAG: d.flag = ee_data_i;
                        eecl_pkg::W_MODE: d.mode = ee_data_i;
                        eecl_pkg::W_FRAME: d.frame = ee_data_i;
                        eecl_pkg::W_PHY: d.phy = ee_data_i;
                        eecl_pkg::W_WM: d.wm = ee_data_i;
                        eecl_pkg::W_CKSUM: d.ck = ee_data_i;
                        eecl_pkg::W_ATTR: d.attr = ee_data_i;
                        eecl_pkg::W_PWR: d.pwr = ee_data_i;
                        default: d.blank = q.blank;
                    endcase
                    if (q.addr >= eecl_pkg::W_MAC0 && q.addr <= eecl_pkg::W_MAC2) begin
                        d.mac = {ee_data_i, q.mac[47:16]};
                    end
                    if (q.addr >= eecl_pkg::W_CK_FIRST && q.addr <= eecl_pkg::W_CK_LAST) begin
                        d.sum = q.sum + ee_data_i[7:0] + ee_data_i[15:8]; // RL25
                    end
                    if (q.addr == eecl_pkg::W_PWR) begin
                        d.st = S_CHECK;
                    end else begin
                        d.addr = next_addr(q.addr); // RL24
                        d.st = S_REQ;
                    end
                end
            end
            // validate, fall back to the fixed image
            S_CHECK: begin
                d.bad = (eecl_pkg::CKSUM_SEED - q.sum) != q.ck[7:0]; // RL25
                if (q.blank || d.bad) begin
                    d.use_rom = 1'b1; // RL15
                    d.flag = eecl_pkg::ROM_FLAG; // RL22
                    d.mode = eecl_pkg::ROM_MODE; // RL19
                    d.frame = eecl_pkg::ROM_FRAME;
                    d.phy = eecl_pkg::ROM_PHY; // RL7
                    d.wm = eecl_pkg::ROM_WM;
                    d.ck = eecl_pkg::ROM_CKSUM; // RL18
                    d.attr = eecl_pkg::ROM_ATTR;
                    d.pwr = eecl_pkg::ROM_PWR;
                    d.mac = 48'h0000_0000_0000; // RL17
                end
                d.st = S_APPLY;
            end
            // decode and release the embedded phy
            S_APPLY: begin
                d.autoneg = msel == eecl_pkg::MODE_AUTO_ALL // RL2
                    || msel == eecl_pkg::MODE_AUTO_100
                    || msel == eecl_pkg::MODE_AUTO_10;
                d.s100 = msel == eecl_pkg::MODE_AUTO_ALL
                    || msel == eecl_pkg::MODE_AUTO_100
                    || msel == eecl_pkg::MODE_100FDX
                    || msel == eecl_pkg::MODE_100HDX;
                d.fdx = !(msel == eecl_pkg::MODE_100HDX
                    || msel == eecl_pkg::MODE_10HDX); // RL1
                if (q.frame[0] || q.frame[11:0] > eecl_pkg::FRAME_MAX
                    || q.frame[15:12] != 4'h0) begin
                    d.max_frame = eecl_pkg::FRAME_DEF; // RL5
                end else begin
                    d.max_frame = q.frame[11:0]; // RL5
                end
                d.attr[15] = 1'b1; // RL20
                d.ephy_rst_n = 1'b1; // RL3
                d.valid = 1'b1; // RL26
                d.straps = q.sy2;
                d.pd_idx = 2'd0;
                if (q.sy2[1] && !q.sy2[0]) begin
                    d.st = S_PD; // RL13
                end else begin
                    d.st = S_RUN; // RL14
                end
            end
            // power-down writes in fixed order
            S_PD: begin
                d.mwr = 1'b1;
                d.mreg = eecl_pkg::PD_REG; // RL12
                d.mdata = eecl_pkg::PD_DATA;
                case (q.pd_idx)
                    2'd0: d.mphy = eecl_pkg::PD_BCAST; // RL12
                    2'd1: d.mphy = q.phy[4:0]; // RL12
                    default: d.mphy = q.phy[12:8]; // RL12
                endcase
                d.st = S_PD_WAIT;
            end
            S_PD_WAIT: begin
                if (mdio_done_i) begin
                    if (q.pd_idx == 2'd2) begin
                        d.pd_done = 1'b1;
                        d.st = S_RUN;
                    end else begin
                        d.pd_idx = q.pd_idx + 2'd1;
                        d.st = S_PD;
                    end
                end
            end
            // host phy register writes after the latch
            S_RUN: begin
                if (q.hpend) begin
                    d.mwr = 1'b1; // RL4
                    d.mphy = q.sel_phy;
                    d.mreg = q.sel_reg;
                    d.mdata = q.hdata;
                    d.hpend = 1'b0;
                    d.st = S_HW_WAIT;
                end
            end
            S_HW_WAIT: begin
                if (mdio_done_i) begin
                    d.st = S_RUN;
                end
            end
            default: d.st = S_REQ;
        endcase
        if (reg_wr_i && reg_addr_i == eecl_pkg::A_PHYDATA) begin
            d.hpend = 1'b1;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign ee_rd_o = q.rd;
    assign ee_addr_o = q.addr;
    assign mdio_wr_o = q.mwr;
    assign mdio_phy_o = q.mphy;
    assign mdio_reg_o = q.mreg;
    assign mdio_data_o = q.mdata;
    assign reg_rdata_o = q.rdata;
    assign cfg_valid_o = q.valid;
    assign ephy_rst_n_o = q.ephy_rst_n;
    assign embedded_phy_mode_sel_o = q.mode[15:13];
    assign ephy_autoneg_o = q.autoneg;
    assign ephy_speed100_o = q.s100;
    assign ephy_full_duplex_o = q.fdx;
    assign max_frame_o = q.max_frame;
    assign prim_phy_kind_code_o = q.phy[7:5]; // RL6
    assign prim_phy_mgmt_addr_o = q.phy[4:0];
    assign sec_phy_kind_code_o = q.phy[15:13]; // RL6
    assign external_media_port_addr_o = q.phy[12:8]; // RL8
    assign pause_o = q.pause;
    assign jam_o = q.jam;
    assign mac_addr_o = q.mac;
    assign cfg_attr_o = q.attr[15:8]; // RL20
    assign max_power_o = q.pwr[7:0]; // RL21
    assign self_powered_o = q.flag[0]; // RL22
    assign remote_wakeup_o = q.flag[2]; // RL22
    assign cable_off_auto_disconnect_o = q.ck[12]; // RL23
    assign cable_off_level_o = q.ck[9:8]; // RL23

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_mode_fixed;
        (q.valid && msel == eecl_pkg::MODE_10HDX) |-> !q.autoneg && !q.s100 && !q.fdx;
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("mode 111 not 10M half"); // RL1
    property p_latch_once;
        q.ephy_rst_n |=> q.ephy_rst_n && $stable(q.mode[15:13]);
    endproperty
    a_latch_once: assert property (p_latch_once) else $error("phy mode reapplied"); // RL3
    property p_frame;
        q.valid |-> q.max_frame <= eecl_pkg::FRAME_MAX && !q.max_frame[0];
    endproperty
    a_frame: assert property (p_frame) else $error("frame size out of range"); // RL5
    property p_pause;
        (q.valid && full_duplex_i && free_bytes_i <= hi_b) |=> pause_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause not raised"); // RL9
    property p_jam;
        jam_o |-> !pause_o && !$past(full_duplex_i);
    endproperty
    a_jam: assert property (p_jam) else $error("jam in full duplex"); // RL11
    property p_pd_order;
        (q.mwr && q.st == S_PD_WAIT && q.pd_idx == 2'd0) |-> q.mphy == eecl_pkg::PD_BCAST
            && q.mreg == eecl_pkg::PD_REG && q.mdata == eecl_pkg::PD_DATA;
    endproperty
    a_pd_order: assert property (p_pd_order) else $error("power-down order wrong"); // RL12
    property p_pd_gate;
        (q.st == S_PD) |-> q.straps == 2'b10;
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("power-down not allowed"); // RL14
    property p_rom_mac;
        (q.valid && q.use_rom) |-> mac_addr_o == 48'h0 && max_power_o == 8'h02;
    endproperty
    a_rom_mac: assert property (p_rom_mac) else $error("built-in image not applied"); // RL17
    property p_attr;
        $rose(q.valid) |-> cfg_attr_o[7] && $past(q.st) == S_APPLY;
    endproperty
    a_attr: assert property (p_attr) else $error("attribute bit 7 clear"); // RL20
    property p_rd;
        (reg_rd_i && reg_addr_i == eecl_pkg::A_STATUS) |=> reg_rdata_o[0] == $past(q.valid);
    endproperty
    a_rd: assert property (p_rd) else $error("status read wrong");
    c_rom: cover property ($rose(q.valid) && q.use_rom);
    c_pd: cover property ($rose(q.pd_done));
    c_pause: cover property ($rose(pause_o));
endmodule : eecl_loader

// File: logic/eecl_pkg.sv
// constants shared by the configuration loader
package eecl_pkg;
    // ************************************************************
    // word offsets of the configuration image
    // ************************************************************
    localparam logic [7:0] PRELOAD_WORDS = 8'h15; // words fetched in order from 00h after reset
    localparam logic [7:0] W_BLANK = 8'h00; // count word, all ones when blank
    localparam logic [7:0] W_FLAG = 8'h01; // power and wakeup flags
    localparam logic [7:0] W_MAC0 = 8'h04; // first station address word
    localparam logic [7:0] W_MAC2 = 8'h06; // last station address word
    localparam logic [7:0] W_CK_FIRST = 8'h07; // first word in the byte sum
    localparam logic [7:0] W_CK_LAST = 8'h0E; // last word in the byte sum
    localparam logic [7:0] W_MODE = 8'h0F; // embedded phy mode in [15:13]
    localparam logic [7:0] W_FRAME = 8'h10; // maximum frame size
    localparam logic [7:0] W_PHY = 8'h11; // phy kind and address bytes
    localparam logic [7:0] W_WM = 8'h12; // watermarks, high mark in [15:8]
    localparam logic [7:0] W_CKSUM = 8'h18; // checksum low, power saving high
    localparam logic [7:0] W_ATTR = 8'h2C; // descriptor attributes in [15:8]
    localparam logic [7:0] W_PWR = 8'h2D; // maximum power in [7:0]
    // ************************************************************
    // fixed built-in image, low byte first
    // ************************************************************
    localparam logic [15:0] ROM_FLAG = 16'h1DFD;
    localparam logic [15:0] ROM_MODE = 16'h0580;
    localparam logic [15:0] ROM_FRAME = 16'h0600;
    localparam logic [15:0] ROM_PHY = 16'hE010;
    localparam logic [15:0] ROM_WM = 16'h2442;
    localparam logic [15:0] ROM_CKSUM = 16'h08FF;
    localparam logic [15:0] ROM_ATTR = 16'hE004;
    localparam logic [15:0] ROM_PWR = 16'h0902;
    localparam logic [15:0] BLANK_WORD = 16'hFFFF;
    localparam logic [7:0] CKSUM_SEED = 8'hFF;
    // ************************************************************
    // field codes and limits
    // ************************************************************
    localparam logic [2:0] MODE_AUTO_ALL = 3'b000;
    localparam logic [2:0] MODE_AUTO_100 = 3'b001;
    localparam logic [2:0] MODE_AUTO_10 = 3'b010;
    localparam logic [2:0] MODE_100FDX = 3'b100;
    localparam logic [2:0] MODE_100HDX = 3'b101;
    localparam logic [2:0] MODE_10FDX = 3'b110;
    localparam logic [2:0] MODE_10HDX = 3'b111;
    localparam logic [2:0] KIND_ETH = 3'b000; // ethernet or phone-line phy
    localparam logic [2:0] KIND_NONE = 3'b111; // no supported phy
    localparam logic [4:0] EPHY_ADDR = 5'h10; // embedded phy management address
    localparam logic [4:0] PD_BCAST = 5'h00; // address reaching every phy
    localparam logic [4:0] PD_REG = 5'h00; // control register
    localparam logic [15:0] PD_DATA = 16'h0800; // power-down bit set
    localparam logic [11:0] FRAME_MAX = 12'h800; // 2048 bytes
    localparam logic [11:0] FRAME_DEF = 12'h600;
    localparam int WM_SHIFT = 7; // one watermark unit is 128 bytes
    // ************************************************************
    // register bus offsets
    // ************************************************************
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_PHYSEL = 8'h04;
    localparam logic [7:0] A_PHYDATA = 8'h08;
    localparam logic [7:0] A_MACLO = 8'h0C;
    localparam logic [7:0] A_MACHI = 8'h10;
endpackage : eecl_pkg
